// *** rtl/apf_cfg.svh ***
`ifndef APF_CFG_SVH
`define APF_CFG_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define APF_ADDR_W        12
`define APF_CTRL_OFFSET   12'h000
`define APF_CTRL_RESET    8'h00
`define APF_CTRL_WMASK    8'h7f
`define APF_RDATA_ZERO    32'h0000_0000
`define APF_RDATA_PAD     24'h00_0000

// ----------------------------------------------------------------------
// Field positions inside the control register
// ----------------------------------------------------------------------
`define APF_BIT_CAPCMP_CH2  0
`define APF_BIT_SLAVE_SEL   1
`define APF_BIT_COMP2_OUT   2
`define APF_BIT_SR_INV      3
`define APF_BIT_PWM2_B      4
`define APF_BIT_TIMER1_GATE 5
`define APF_BIT_CAPCMP_CH3  6
`define APF_LANE_LOW        0

// ----------------------------------------------------------------------
// Strap capture timing and synchroniser lane order
// ----------------------------------------------------------------------
`define APF_STRAP_SETTLE  2'h3
`define APF_STRAP_CNT_ONE 2'h1
`define APF_SYNC_B5       0
`define APF_SYNC_C4       1
`define APF_SYNC_STRAP    2
`define APF_SYNC_W        3

`endif

// *** rtl/apf_pkg.sv ***
package apf_pkg;

	// ------------------------------------------------------------------
	// Shared types
	// ------------------------------------------------------------------

	// Register slave phase tracking.
	typedef enum logic [0:0] {
		apf_idle,
		apf_access
	} apf_apb_state_type;

	// Package variant, caught from a strap after reset.
	typedef enum logic [0:0] {
		apf_pkg_small,
		apf_pkg_large
	} apf_pkg_variant_type;

endpackage

// *** rtl/apf_sync2.sv ***
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Two-stage synchroniser for pin inputs
// ----------------------------------------------------------------------

// The first stage feeds only the second, so no logic sees a metastable
// value.
module apf_sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1;

	// Both stages clear under reset to a constant.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end

endmodule

// *** rtl/apf_pin_drive.sv ***
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Registered output cell for one routed pin
// ----------------------------------------------------------------------

// Drives the pin level and an active-low enable from flip-flops, so the
// pad never sees a glitch from the routing decode.
module apf_pin_drive (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic drive_en,
	input  wire logic drive_val,
	output logic      pin_out,
	output logic      pin_oe_n
);

	logic next_pin_out;
	logic next_pin_oe_n;

	// An unselected pin is released and its level parked low.
	always_comb begin
		next_pin_out  = drive_en ? drive_val : 1'b0;
		next_pin_oe_n = ~drive_en;
	end

	// Reset leaves the pin released.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_out  <= 1'b0;
			pin_oe_n <= 1'b1;
		end else begin
			pin_out  <= next_pin_out;
			pin_oe_n <= next_pin_oe_n;
		end
	end

endmodule

// *** rtl/apf_top.sv ***
`timescale 1ns/10ps
`include "apf_cfg.svh"

// Overview of operation
// - Channel 3 on B5 when set; small package: channel 3 clear goes to C6
// - Large package: channel 3 clear goes to E0
// - Gate select clear: timer gate from B5
// - Gate select set: timer gate from C4
// - PWM B select clear: PWM B on C0
// - Small package: PWM B select set moves to B5 unless channel 3 select is set
module apf_top
	import apf_pkg::*;
(
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic [`APF_ADDR_W-1:0] paddr,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [31:0]            pwdata,
	input  wire logic [3:0]             pstrb,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic                   large_package,
	input  wire logic                   capcmp_ch3_output,
	input  wire logic                   pwm2_b_output,
	output logic                        timer1_gate_input,
	input  wire logic                   port_b_pin5_in,
	output logic                        port_b_pin5_out,
	output logic                        port_b_pin5_oe_n,
	input  wire logic                   port_c_pin4_in,
	output logic                        port_c_pin6_out,
	output logic                        port_c_pin6_oe_n,
	output logic                        port_e_pin0_out,
	output logic                        port_e_pin0_oe_n,
	output logic                        port_c_pin0_out,
	output logic                        port_c_pin0_oe_n,
	output logic                        port_d_pin2_out,
	output logic                        port_d_pin2_oe_n,
	output logic                        package_is_large,
	output logic                        sr_latch_inv_route_sel,
	output logic                        comparator2_out_route_sel,
	output logic                        slave_select_route_sel,
	output logic                        capcmp_ch2_route_sel
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------

	apf_apb_state_type   state;
	apf_apb_state_type   next_state;
	logic [7:0]          ctrl;
	logic [7:0]          next_ctrl;
	logic [31:0]         next_prdata;
	logic                next_pready;
	logic                next_pslverr;
	logic                addr_hit;
	logic                write_commit;

	logic [`APF_SYNC_W-1:0] pins_sync;
	logic [1:0]          strap_cnt;
	logic [1:0]          next_strap_cnt;
	apf_pkg_variant_type pkg_variant;
	apf_pkg_variant_type next_pkg_variant;
	logic                next_package_is_large;

	logic                is_large;
	logic                ch3_on_b5;
	logic                pwm2b_on_b5;
	logic                pwm2b_on_c0;
	logic                pwm2b_on_d2;
	logic                b5_drive_en;
	logic                b5_drive_val;
	logic                next_gate;

	// ------------------------------------------------------------------
	// Pin input synchronisers
	// ------------------------------------------------------------------

	// Pad levels and the package strap come from outside the clock
	// domain, so all of them pass two flip-flops before any decode.
	apf_sync2 #(
		.WIDTH (`APF_SYNC_W)
	) u_pin_sync (
		.clk      (pclk),
		.rst_n    (presetn),
		.async_in ({large_package, port_c_pin4_in, port_b_pin5_in}),
		.sync_out (pins_sync)
	);

	// ------------------------------------------------------------------
	// Register bus slave
	// ------------------------------------------------------------------

	// Only one word is mapped; every other address answers with an error.
	assign addr_hit = (paddr == `APF_CTRL_OFFSET);

	// The write lands on the edge that closes the access phase.
	assign write_commit = (state == apf_access) && psel && penable &&
		pwrite && addr_hit && pstrb[`APF_LANE_LOW];

	// The answer is prepared during setup so that pready can come
	// straight from a flip-flop with no wait state in the access phase.
	always_comb begin
		next_state   = state;
		next_ctrl    = ctrl;
		next_prdata  = prdata;
		next_pready  = 1'b0;
		next_pslverr = 1'b0;
		case (state)
			apf_idle: begin
				if (psel && !penable) begin
					next_state   = apf_access;
					next_pready  = 1'b1;
					next_pslverr = ~addr_hit;
					if (!pwrite && addr_hit) begin
						// Unimplemented top bit always reads zero.
						next_prdata = {`APF_RDATA_PAD,
							ctrl & `APF_CTRL_WMASK};
					end else begin
						next_prdata = `APF_RDATA_ZERO;
					end
				end
			end
			apf_access: begin
				next_state = apf_idle;
				if (write_commit) begin
					// Writes to the top bit are dropped.
					next_ctrl = pwdata[7:0] & `APF_CTRL_WMASK;
				end
			end
			default: begin
				next_state = apf_idle;
			end
		endcase
	end

	// A reset of any kind returns every route to its default pin.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state   <= apf_idle;
			ctrl    <= `APF_CTRL_RESET;
			prdata  <= `APF_RDATA_ZERO;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			state   <= next_state;
			ctrl    <= next_ctrl;
			prdata  <= next_prdata;
			pready  <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// ------------------------------------------------------------------
	// Package strap capture
	// ------------------------------------------------------------------

	// The strap is taken once, after the synchroniser has filled with
	// real pad samples; until then the small package is assumed, so on a large
	// package channel 3 is driven on C6 for the first few cycles after reset.
	always_comb begin
		next_strap_cnt        = strap_cnt;
		next_pkg_variant      = pkg_variant;
		next_package_is_large = package_is_large;
		if (strap_cnt != `APF_STRAP_SETTLE) begin
			next_strap_cnt = strap_cnt + `APF_STRAP_CNT_ONE;
			if (strap_cnt == (`APF_STRAP_SETTLE - `APF_STRAP_CNT_ONE)) begin
				next_pkg_variant = pins_sync[`APF_SYNC_STRAP] ?
					apf_pkg_large : apf_pkg_small;
				next_package_is_large = pins_sync[`APF_SYNC_STRAP];
			end
		end
	end

	// Constants only under reset; the pad level is caught afterwards.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_cnt        <= 2'h0;
			pkg_variant      <= apf_pkg_small;
			package_is_large <= 1'b0;
		end else begin
			strap_cnt        <= next_strap_cnt;
			pkg_variant      <= next_pkg_variant;
			package_is_large <= next_package_is_large;
		end
	end

	// ------------------------------------------------------------------
	// Route decode
	// ------------------------------------------------------------------

	assign is_large = (pkg_variant == apf_pkg_large);

	// Channel 3 sits on B5 whenever its select is set, on any package.
	assign ch3_on_b5 = ctrl[`APF_BIT_CAPCMP_CH3];

	// PWM B stays on C0 while its select is clear.
	assign pwm2b_on_c0 = ~ctrl[`APF_BIT_PWM2_B];

	// Set select on the small package moves PWM B onto B5 unless channel 3 select is set.
	assign pwm2b_on_b5 = ctrl[`APF_BIT_PWM2_B] && !is_large;

	// The large package has its own alternate pin for PWM B.
	assign pwm2b_on_d2 = ctrl[`APF_BIT_PWM2_B] && is_large;

	// B5 can be claimed by two outputs at once; channel 3 wins so that
	// a careless setting never shorts two drivers onto the pad.
	always_comb begin
		b5_drive_en  = ch3_on_b5 || pwm2b_on_b5;
		b5_drive_val = ch3_on_b5 ? capcmp_ch3_output : pwm2_b_output;
	end

	// ------------------------------------------------------------------
	// Timer 1 gate input selection
	// ------------------------------------------------------------------

	// The gate source follows its select bit; both pads are already
	// synchronised so switching cannot expose a metastable level.
	always_comb begin
		if (ctrl[`APF_BIT_TIMER1_GATE]) begin
			next_gate = pins_sync[`APF_SYNC_C4];
		end else begin
			next_gate = pins_sync[`APF_SYNC_B5];
		end
	end

	// The gate reaches the timer from a flip-flop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer1_gate_input <= 1'b0;
		end else begin
			timer1_gate_input <= next_gate;
		end
	end

	// ------------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------------

	// A new routing shows on the pads one edge after the write edge.
	apf_pin_drive u_drv_b5 (
		.clk       (pclk),
		.rst_n     (presetn),
		.drive_en  (b5_drive_en),
		.drive_val (b5_drive_val),
		.pin_out   (port_b_pin5_out),
		.pin_oe_n  (port_b_pin5_oe_n)
	);

	// Small package fallback pin for channel 3.
	apf_pin_drive u_drv_c6 (
		.clk       (pclk),
		.rst_n     (presetn),
		.drive_en  (!ch3_on_b5 && !is_large),
		.drive_val (capcmp_ch3_output),
		.pin_out   (port_c_pin6_out),
		.pin_oe_n  (port_c_pin6_oe_n)
	);

	// Large package fallback pin for channel 3.
	apf_pin_drive u_drv_e0 (
		.clk       (pclk),
		.rst_n     (presetn),
		.drive_en  (!ch3_on_b5 && is_large),
		.drive_val (capcmp_ch3_output),
		.pin_out   (port_e_pin0_out),
		.pin_oe_n  (port_e_pin0_oe_n)
	);

	// Default pin for PWM B on both packages.
	apf_pin_drive u_drv_c0 (
		.clk       (pclk),
		.rst_n     (presetn),
		.drive_en  (pwm2b_on_c0),
		.drive_val (pwm2_b_output),
		.pin_out   (port_c_pin0_out),
		.pin_oe_n  (port_c_pin0_oe_n)
	);

	// Alternate PWM B pin present only on the large package.
	apf_pin_drive u_drv_d2 (
		.clk       (pclk),
		.rst_n     (presetn),
		.drive_en  (pwm2b_on_d2),
		.drive_val (pwm2_b_output),
		.pin_out   (port_d_pin2_out),
		.pin_oe_n  (port_d_pin2_oe_n)
	);

	// ------------------------------------------------------------------
	// Remaining select bits
	// ------------------------------------------------------------------

	// These routes belong to other pad groups; the bits are exported
	// straight from the register so those groups can decode them.
	assign sr_latch_inv_route_sel    = ctrl[`APF_BIT_SR_INV];
	assign comparator2_out_route_sel = ctrl[`APF_BIT_COMP2_OUT];
	assign slave_select_route_sel    = ctrl[`APF_BIT_SLAVE_SEL];
	assign capcmp_ch2_route_sel      = ctrl[`APF_BIT_CAPCMP_CH2];

endmodule

// *** dv/apf_top_asserts.sv ***
`timescale 1ns/10ps
`include "apf_cfg.svh"

// ----------------------------------------------------------------------
// Port-level checks on the pin router
// ----------------------------------------------------------------------

module apf_chk (
	input wire logic			pclk,
	input wire logic			presetn,
	input wire logic [`APF_ADDR_W-1:0]	paddr,
	input wire logic			psel,
	input wire logic			penable,
	input wire logic [31:0]		prdata,
	input wire logic			pready,
	input wire logic			pslverr,
	input wire logic			capcmp_ch3_output,
	input wire logic			pwm2_b_output,
	input wire logic			timer1_gate_input,
	input wire logic			port_b_pin5_in,
	input wire logic			port_c_pin4_in,
	input wire logic			port_b_pin5_out,
	input wire logic			port_b_pin5_oe_n,
	input wire logic			port_c_pin6_out,
	input wire logic			port_c_pin6_oe_n,
	input wire logic			port_e_pin0_out,
	input wire logic			port_e_pin0_oe_n,
	input wire logic			port_c_pin0_out,
	input wire logic			port_c_pin0_oe_n,
	input wire logic			port_d_pin2_out,
	input wire logic			port_d_pin2_oe_n,
	input wire logic			package_is_large
);
	logic [2:0]	up_cnt;
	logic [2:0]	next_up_cnt;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Cycles since reset, so the pad-history check skips stale samples.
	always_comb next_up_cnt = (up_cnt == 3'h7) ? up_cnt : up_cnt + 3'h1;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) up_cnt <= 3'h0;
		else up_cnt <= next_up_cnt;
	end

	// Channel 3 fallback pins follow the captured package strap.
	AST_C6_CH3: assert property (
		!port_c_pin6_oe_n |-> !$past(package_is_large) &&
		port_c_pin6_out == $past(capcmp_ch3_output))
		else $error("c6 bad");
	AST_E0_CH3: assert property (
		!port_e_pin0_oe_n |-> $past(package_is_large) &&
		port_e_pin0_out == $past(capcmp_ch3_output))
		else $error("e0 bad");
	AST_CH3_ONE: assert property (
		port_c_pin6_oe_n || port_e_pin0_oe_n)
		else $error("c6 and e0 both driven");
	AST_B5_OUT: assert property (
		!port_b_pin5_oe_n |-> port_b_pin5_out ==
		((port_c_pin6_oe_n && port_e_pin0_oe_n) ?
		$past(capcmp_ch3_output) : $past(pwm2_b_output)))
		else $error("b5 bad");
	AST_C0_PWM: assert property (
		!port_c_pin0_oe_n |->
		port_c_pin0_out == $past(pwm2_b_output))
		else $error("c0 bad");
	AST_D2_PWM: assert property (
		!port_d_pin2_oe_n |-> port_c_pin0_oe_n &&
		port_d_pin2_out == $past(pwm2_b_output))
		else $error("d2 bad");
	AST_GATE_SRC: assert property (
		up_cnt > 3'h3 |->
		timer1_gate_input == $past(port_b_pin5_in, 3) ||
		timer1_gate_input == $past(port_c_pin4_in, 3))
		else $error("gate bad");
	AST_ZERO_WAIT: assert property (
		psel && !penable |=> pready ##1 !pready)
		else $error("pready bad");
	AST_ERR_MAP: assert property (
		pready |-> pslverr == (paddr != `APF_CTRL_OFFSET))
		else $error("pslverr bad");
	AST_TOP_ZERO: assert property (
		pready |-> prdata[31:7] == 25'h0)
		else $error("top bits set");
endmodule

bind apf_top apf_chk u_apf_chk (.*);

// *** dv/apf_top_tb_top.sv ***
`timescale 1ns/10ps

module apf_top_tb_top;
	localparam logic [11:0] ctrl_addr = 12'h000;
	localparam logic [11:0] bad_addr  = 12'h004;
	localparam logic [33:0] wr_ok     = 34'h0_0000_0000;
	localparam logic [33:0] wr_err    = 34'h1_0000_0000;
	localparam logic [33:0] rd_zero   = 34'h2_0000_0000;
	localparam logic [33:0] rd_err    = 34'h3_0000_0000;

	logic		pclk = 0;
	logic		presetn = 0;
	logic		psel = 0;
	logic		penable = 0;
	logic		pwrite = 0;
	logic		large_package = 0;
	logic		ch3 = 0, pwm = 0, b5 = 0, c4 = 0;
	logic		probe = 0;
	logic [11:0]	paddr = '0;
	logic [31:0]	pwdata = '0;
	logic [31:0]	prdata;
	logic [31:0]	rng = 32'd90799;
	logic [3:0]	pstrb = '0;
	logic [3:0]	lo;
	logic		pready, pslverr, gate, big;
	logic		b5o, b5e, c6o, c6e, e0o, e0e, c0o, c0e, d2o, d2e;
	logic [33:0]	rq[$];
	logic [15:0]	pq[$];
	int		n_errors = 0, num_checks = 0;

	always #2.5 pclk = ~pclk;

	apf_top u_apf_top (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.large_package(large_package), .capcmp_ch3_output(ch3),
		.pwm2_b_output(pwm), .timer1_gate_input(gate),
		.port_b_pin5_in(b5), .port_b_pin5_out(b5o), .port_b_pin5_oe_n(b5e),
		.port_c_pin4_in(c4), .port_c_pin6_out(c6o), .port_c_pin6_oe_n(c6e),
		.port_e_pin0_out(e0o), .port_e_pin0_oe_n(e0e),
		.port_c_pin0_out(c0o), .port_c_pin0_oe_n(c0e),
		.port_d_pin2_out(d2o), .port_d_pin2_oe_n(d2e),
		.package_is_large(big), .sr_latch_inv_route_sel(lo[3]),
		.comparator2_out_route_sel(lo[2]), .slave_select_route_sel(lo[1]),
		.capcmp_ch2_route_sel(lo[0]));

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------

	// Xorshift source; a fixed start keeps every run repeatable.
	function logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction

	// Expected pads as {oe_n, out} pairs B5, C6, E0, C0, D2, then gate.
	function logic [10:0] route(input logic [7:0] s, input logic lg,
		input logic c3, input logic pw, input logic pb, input logic pc);
		logic b, c6, e0, c0, d2;
		c6 = !s[6] && !lg;
		e0 = !s[6] && lg;
		b = s[6] || (s[4] && !lg);
		c0 = !s[4];
		d2 = s[4] && lg;
		return {!b, b && (s[6] ? c3 : pw), !c6, c6 && c3, !e0, e0 && c3,
			!c0, c0 && pw, !d2, d2 && pw, s[5] ? pc : pb};
	endfunction

	task stop_test();
		$display("errors %0d checks %0d", n_errors, num_checks);
		if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task cmp(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One transfer; returns on the completing edge without releasing, so
	// a following call forms a legal back-to-back setup. pready is read
	// right after each rising edge, which still shows the sampled value.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] st, input logic [33:0] ex);
		int n;
		rq.push_back(ex);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= st;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (!pready && n < 20);
		if (!pready) begin
			n_errors++;
			stop_test();
		end
	endtask

	// ------------------------------------------------------------------
	// Monitor: mid-cycle sampling keeps clear of edge races
	// ------------------------------------------------------------------

	always @(negedge pclk) begin
		logic [33:0] e;
		if (psel && penable && pready) begin
			e = rq.pop_front();
			cmp({31'h0, pslverr}, {31'h0, e[32]});
			if (e[33]) cmp(prdata, e[31:0]);
		end
	end

	// Strap with B5, C6 and E0, then C0 and D2, then gate, then exported selects, one compare each.
	always @(negedge pclk) if (probe) begin
		logic [15:0] p;
		logic [15:0] g;
		p = pq.pop_front();
		g = {lo, big, b5e, b5o, c6e, c6o, e0e, e0o,
			c0e, c0o, d2e, d2o, gate};
		cmp({25'h0, g[11:5]}, {25'h0, p[11:5]});
		cmp({28'h0, g[4:1]}, {28'h0, p[4:1]});
		cmp({31'h0, g[0]}, {31'h0, p[0]});
		cmp({28'h0, g[15:12]}, {28'h0, p[15:12]});
	end

	// ------------------------------------------------------------------
	// Stimulus: both package straps, every setting of bits 6 to 4
	// ------------------------------------------------------------------

	initial begin
		logic [7:0] v;
		logic [31:0] d;
		logic [33:0] ex;
		int i, k;
		for (k = 0; k < 2; k++) begin
			presetn <= 1'b0;
			large_package <= k[0];
			repeat (12) @(posedge pclk);
			presetn <= 1'b1;
			@(posedge pclk);
			apb(1'b0, ctrl_addr, 32'h0, 4'hf, rd_zero);
			apb(1'b1, ctrl_addr, 32'hff, 4'he, wr_ok);
			apb(1'b0, ctrl_addr, 32'h0, 4'hf, rd_zero);
			for (i = 0; i < 8; i++) begin
				rng = xs();
				v = rng[7:0];
				v[6:4] = i[2:0];
				d = {rng[31:8], v};
				ex = {2'b10, 25'h0, v[6:0]};
				apb(1'b1, ctrl_addr, d, 4'hf, wr_ok);
				apb(1'b1, bad_addr, d, 4'hf, wr_err);
				apb(1'b0, bad_addr, 32'h0, 4'hf, rd_err);
				apb(1'b0, ctrl_addr, 32'h0, 4'hf, ex);
				psel <= 1'b0;
				penable <= 1'b0;
				rng = xs();
				{ch3, pwm, b5, c4} <= rng[3:0];
				repeat (5) @(posedge pclk);
				pq.push_back({v[3:0], k[0],
					route(v, k[0], ch3, pwm, b5, c4)});
				probe <= 1'b1;
				@(posedge pclk);
				probe <= 1'b0;
			end
		end
		stop_test();
	end
endmodule
